// [rtl/mcelog_pkg.sv]
// package: field layout, bank map and event carriers for the memory error misc log
package mcelog_pkg;
  localparam int unsigned MCELOG_DATA_W = 64;
  localparam int unsigned MCELOG_ID_W = 5;
  localparam int unsigned MCELOG_MASK_W = 16;
  localparam int unsigned MCELOG_RANK_W = 5;
  localparam int unsigned MCELOG_ADDR_W = 9;
  // field positions within the misc log word
  localparam int unsigned MCELOG_ADDR_LSB = 0;
  localparam int unsigned MCELOG_ID_LSB = 9;
  localparam int unsigned MCELOG_MASK1_LSB = 14;
  localparam int unsigned MCELOG_MASK2_LSB = 30;
  localparam int unsigned MCELOG_RANK1_LSB = 46;
  localparam int unsigned MCELOG_RANK2_LSB = 51;
  localparam int unsigned MCELOG_RSVD_LSB = 56;
  localparam int unsigned MCELOG_RSVD_W = 6;
  localparam int unsigned MCELOG_VALID1_BIT = 62;
  localparam int unsigned MCELOG_VALID2_BIT = 63;
  // extended logging control bit position
  localparam int unsigned MCELOG_EXT_CTRL_BIT = 1;
  localparam int unsigned MCELOG_CTRL_W = 2;
  // bank numbering
  localparam int unsigned MCELOG_BANK_W = 5;
  localparam logic [4:0] MCELOG_HA_BANK_C0 = 5'h07;
  localparam logic [4:0] MCELOG_HA_BANK_C1 = 5'h08;
  localparam logic [4:0] MCELOG_IMC_BANK_C0_LO = 5'h09;
  localparam logic [4:0] MCELOG_IMC_BANK_C1_LO = 5'h0D;
  localparam int unsigned MCELOG_CH_PER_CTRL = 4;
  localparam int unsigned MCELOG_NUM_IMC_BANKS = 8;
  localparam int unsigned MCELOG_NUM_BANKS = 10;
  // error kinds reported by the controller
  typedef enum logic [1:0] {
    MCELOG_KIND_WR_DATA_PAR = 2'b00,
    MCELOG_KIND_WR_BE_PAR = 2'b01,
    MCELOG_KIND_CORR_READ = 2'b10,
    MCELOG_KIND_OTHER = 2'b11
  } mcelog_kind_e;
  // one error event from a controller
  typedef struct packed {
    logic valid;
    logic ctrl;
    logic [1:0] channel;
    logic home_agent;
    mcelog_kind_e kind;
    logic [8:0] addr_info;
    logic [4:0] write_data_buffer;
    logic [4:0] device_id;
    logic [15:0] device_bit_mask;
    logic [4:0] failing_rank;
  } mcelog_evt_s;
  // software write or clear of one bank
  typedef struct packed {
    logic wr;
    logic clr;
    logic [4:0] bank;
    logic [63:0] data;
  } mcelog_sw_s;
endpackage

// [rtl/mcelog_bank.sv]
// one misc log bank: captures event fields and holds them until software or a later event changes them
`timescale 1ns/1ps
module mcelog_bank
  import mcelog_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic ext_log_en,
  input wire logic hit,
  input wire mcelog_evt_s evt,
  input wire logic sw_wr,
  input wire logic sw_clr,
  input wire logic [MCELOG_DATA_W-1:0] sw_data,
  output logic [MCELOG_DATA_W-1:0] log_q
);
  logic [MCELOG_DATA_W-1:0] log_d;
  logic first_seen;
  logic is_wr_par;
  logic is_corr;

  // decode event class
  assign is_wr_par = (evt.kind == MCELOG_KIND_WR_DATA_PAR) || (evt.kind == MCELOG_KIND_WR_BE_PAR);
  assign is_corr = (evt.kind == MCELOG_KIND_CORR_READ);
  assign first_seen = log_q[MCELOG_VALID1_BIT];

  // next value: event capture wins over a same-cycle software write
  always_comb begin
    log_d = log_q;
    if (sw_clr) begin
      log_d = '0;
    end else if (sw_wr) begin
      log_d = sw_data;
    end
    if (hit) begin
      log_d[MCELOG_ADDR_LSB +: MCELOG_ADDR_W] = evt.addr_info;
      if (is_wr_par) begin
        log_d[MCELOG_ID_LSB +: MCELOG_ID_W] = evt.write_data_buffer;
      end else if (is_corr && ext_log_en) begin
        if (!log_d[MCELOG_VALID1_BIT]) begin
          log_d[MCELOG_MASK1_LSB +: MCELOG_MASK_W] = evt.device_bit_mask;
          log_d[MCELOG_RANK1_LSB +: MCELOG_RANK_W] = evt.failing_rank;
          log_d[MCELOG_VALID1_BIT] = 1'b1;
        end else begin
          log_d[MCELOG_ID_LSB +: MCELOG_ID_W] = evt.device_id;
          log_d[MCELOG_MASK2_LSB +: MCELOG_MASK_W] = evt.device_bit_mask;
          log_d[MCELOG_RANK2_LSB +: MCELOG_RANK_W] = evt.failing_rank;
          log_d[MCELOG_VALID2_BIT] = 1'b1;
        end
      end
    end
    log_d[MCELOG_RSVD_LSB +: MCELOG_RSVD_W] = '0;
  end

  // register holds until software or a new event changes it
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      log_q <= '0;
    end else if (clk_en) begin
      log_q <= log_d;
    end
  end

  // first_seen only documents the ordering dependency for readers
  logic unused_ok;
  assign unused_ok = first_seen;
endmodule

// [rtl/mcelog_top.sv]
// memory controller extended misc log: bank map, capture control and read port
`timescale 1ns/1ps
module mcelog_top
  import mcelog_pkg::*;
#(
  parameter int unsigned NUM_IMC_BANKS = MCELOG_NUM_IMC_BANKS
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [MCELOG_CTRL_W-1:0] extended_logging_control,
  input wire mcelog_evt_s evt,
  input wire mcelog_sw_s sw,
  input wire logic [MCELOG_BANK_W-1:0] rd_bank,
  output logic [MCELOG_DATA_W-1:0] memory_error_misc_log,
  output logic [MCELOG_BANK_W-1:0] last_bank_q,
  output logic rd_hit_q
);
  localparam int unsigned NB = NUM_IMC_BANKS + 2;

  // elaboration check: the bank map is fixed at eight controller banks
  if (NUM_IMC_BANKS != MCELOG_NUM_IMC_BANKS) begin : g_bad_bank_count
    $error("mcelog_top: bank count must match the fixed bank map");
  end

  logic ext_log_q;
  logic [NB-1:0] hit;
  logic [NB-1:0] swsel;
  logic [MCELOG_DATA_W-1:0] bank_log [NB];
  logic [MCELOG_BANK_W-1:0] dest_bank;
  logic [MCELOG_BANK_W-1:0] bank_num [NB];
  logic [MCELOG_DATA_W-1:0] rd_d;
  logic rd_hit_d;

  // control bit registered on the core clock
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ext_log_q <= 1'b0;
    end else if (clk_en) begin
      ext_log_q <= extended_logging_control[MCELOG_EXT_CTRL_BIT];
    end
  end

  // route event to its bank number
  always_comb begin
    if (evt.home_agent) begin
      dest_bank = evt.ctrl ? MCELOG_HA_BANK_C1 : MCELOG_HA_BANK_C0;
    end else begin
      dest_bank = (evt.ctrl ? MCELOG_IMC_BANK_C1_LO : MCELOG_IMC_BANK_C0_LO)
                  + {3'h0, evt.channel};
    end
  end

  // bank numbers: index 0,1 home agent, then 9..16
  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_bank
      if (g < 2) begin : g_ha
        assign bank_num[g] = (g == 0) ? MCELOG_HA_BANK_C0 : MCELOG_HA_BANK_C1;
      end else begin : g_imc
        assign bank_num[g] = MCELOG_IMC_BANK_C0_LO + MCELOG_BANK_W'(g - 2);
      end
      assign hit[g] = evt.valid && (dest_bank == bank_num[g]);
      assign swsel[g] = (sw.bank == bank_num[g]);
      mcelog_bank u_bank (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .ext_log_en(ext_log_q),
        .hit(hit[g]),
        .evt(evt),
        .sw_wr(sw.wr && swsel[g]),
        .sw_clr(sw.clr && swsel[g]),
        .sw_data(sw.data),
        .log_q(bank_log[g])
      );
    end
  endgenerate

  // read mux, unmapped bank reads zero
  always_comb begin
    rd_d = '0;
    rd_hit_d = 1'b0;
    for (int i = 0; i < NB; i++) begin
      if (rd_bank == bank_num[i]) begin
        rd_d = bank_log[i];
        rd_hit_d = 1'b1;
      end
    end
  end

  // registered read data and last logged bank
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      memory_error_misc_log <= '0;
      rd_hit_q <= 1'b0;
      last_bank_q <= '0;
    end else if (clk_en) begin
      memory_error_misc_log <= rd_d;
      rd_hit_q <= rd_hit_d;
      if (evt.valid) begin
        last_bank_q <= dest_bank;
      end
    end
  end
endmodule

// [tb/mcelog_top_monitor.sv]
// checker: bank map, read port and hold relations of the misc log
`timescale 1ns/1ps
module mcelog_top_monitor
  import mcelog_pkg::*;
#(
  parameter int unsigned NUM_IMC_BANKS = MCELOG_NUM_IMC_BANKS
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [MCELOG_CTRL_W-1:0] extended_logging_control,
  input wire mcelog_evt_s evt,
  input wire mcelog_sw_s sw,
  input wire logic [MCELOG_BANK_W-1:0] rd_bank,
  input wire logic [MCELOG_DATA_W-1:0] memory_error_misc_log,
  input wire logic [MCELOG_BANK_W-1:0] last_bank_q,
  input wire logic rd_hit_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // event target bank, mapped read, quiet cycle
  wire logic [4:0] eb = MCELOG_IMC_BANK_C0_LO + {2'b00, evt.ctrl, evt.channel};
  wire logic mapped = rd_bank >= MCELOG_HA_BANK_C0 && rd_bank < 5'(9 + NUM_IMC_BANKS);
  wire logic quiet = clk_en && !evt.valid && !sw.wr && !sw.clr;
  property p_rsvd; memory_error_misc_log[61:56] == 6'h00; endproperty
  property p_hit; clk_en |=> rd_hit_q == $past(mapped); endproperty
  property p_miss; clk_en && !mapped |=> memory_error_misc_log == 64'h0; endproperty
  property p_ha; clk_en && evt.valid && evt.home_agent |=>
    last_bank_q == ($past(evt.ctrl) ? MCELOG_HA_BANK_C1 : MCELOG_HA_BANK_C0); endproperty
  property p_imc; clk_en && evt.valid && !evt.home_agent |=> last_bank_q == $past(eb); endproperty
  property p_hold; !clk_en |=> $stable(last_bank_q) && $stable(memory_error_misc_log); endproperty
  property p_idle; quiet ##1 $stable(rd_bank) |=> $stable(memory_error_misc_log); endproperty
  property p_wdb; clk_en && evt.valid && !evt.home_agent && evt.kind == MCELOG_KIND_WR_DATA_PAR && !sw.wr && !sw.clr
    ##1 (clk_en && rd_bank == $past(eb)) |=> memory_error_misc_log[13:9] == $past(evt.write_data_buffer, 2); endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  a_hit: assert property (p_hit) else $error("read hit flag wrong");
  a_miss: assert property (p_miss) else $error("unmapped read not zero");
  a_ha: assert property (p_ha) else $error("home agent bank wrong");
  a_imc: assert property (p_imc) else $error("controller bank wrong");
  a_hold: assert property (p_hold) else $error("state moved while frozen");
  a_idle: assert property (p_idle) else $error("log changed while idle");
  a_wdb: assert property (p_wdb) else $error("buffer entry not logged");
  c_ha: cover property (evt.valid && evt.home_agent);
  c_v2: cover property (memory_error_misc_log[63]);
  c_miss: cover property (clk_en && !mapped);
endmodule
bind mcelog_top mcelog_top_monitor #(.NUM_IMC_BANKS(NUM_IMC_BANKS)) i_mon (.ref_clk(ref_clk), .rstn(rstn),
  .clk_en(clk_en), .extended_logging_control(extended_logging_control), .evt(evt), .sw(sw), .rd_bank(rd_bank),
  .memory_error_misc_log(memory_error_misc_log), .last_bank_q(last_bank_q), .rd_hit_q(rd_hit_q));

// [tb/mcelog_top_tb_top.sv]
// self-checking bench for the memory error misc log
`timescale 1ns/1ps
module mcelog_top_tb_top;
  import mcelog_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic [1:0] ext = 2'h0;
  mcelog_evt_s evt = '0;
  mcelog_sw_s sw = '0;
  logic [4:0] rd_bank = 5'h00;
  logic [63:0] misc;
  logic [4:0] last;
  logic hit;
  int bad_count = 0;
  int samples_checked = 0;
  // 200 MHz core clock
  always #2.5 ref_clk = ~ref_clk;
  mcelog_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .extended_logging_control(ext), .evt(evt),
    .sw(sw), .rd_bank(rd_bank), .memory_error_misc_log(misc), .last_bank_q(last), .rd_hit_q(hit));
  // compare and count
  task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // misc word built field by field
  function automatic logic [63:0] w(logic v2, logic v1, logic [4:0] r2, logic [4:0] r1, logic [15:0] m2,
    logic [15:0] m1, logic [4:0] id, logic [8:0] ad);
    return {v2, v1, 6'h00, r2, r1, m2, m1, id, ad};
  endfunction
  // one event pulse
  task automatic ev(logic ha, logic c, logic [1:0] ch, mcelog_kind_e k, logic [4:0] b, logic [4:0] id,
    logic [15:0] m, logic [4:0] r, logic [8:0] ad);
    @(posedge ref_clk);
    evt <= '{1'b1, c, ch, ha, k, ad, b, id, m, r};
    @(posedge ref_clk);
    evt <= '0;
  endtask
  // read one bank and its hit flag
  task automatic rd(logic [4:0] b, logic [63:0] e, logic h);
    @(posedge ref_clk);
    rd_bank <= b;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("misc", misc, e);
    chk("hit", {63'h0, hit}, {63'h0, h});
  endtask
  // parity errors, both kinds, both controllers
  task automatic t_wdb();
    ev(0, 0, 2'h0, MCELOG_KIND_WR_DATA_PAR, 5'h15, 5'h03, 16'hFFFF, 5'h1F, 9'h1A5);
    rd(5'h09, w(0, 0, 0, 0, 0, 0, 5'h15, 9'h1A5), 1);
    ev(0, 1, 2'h3, MCELOG_KIND_WR_BE_PAR, 5'h0A, 5'h1C, 16'h1234, 5'h02, 9'h04B);
    rd(5'h10, w(0, 0, 0, 0, 0, 0, 5'h0A, 9'h04B), 1);
    $display("wdb done");
  endtask
  // first then second correctable read with extended capture
  task automatic t_ext();
    @(posedge ref_clk);
    ext <= 2'b10;
    ev(0, 0, 2'h1, MCELOG_KIND_CORR_READ, 5'h00, 5'h04, 16'hA5C3, 5'h11, 9'h0F0);
    rd(5'h0A, w(0, 1, 0, 5'h11, 0, 16'hA5C3, 0, 9'h0F0), 1);
    ev(0, 0, 2'h1, MCELOG_KIND_CORR_READ, 5'h00, 5'h0B, 16'h3C5A, 5'h06, 9'h0F0);
    rd(5'h0A, w(1, 1, 5'h06, 5'h11, 16'h3C5A, 16'hA5C3, 5'h0B, 9'h0F0), 1);
    @(posedge ref_clk);
    ext <= 2'b01;
    ev(0, 1, 2'h0, MCELOG_KIND_CORR_READ, 5'h00, 5'h07, 16'hFFFF, 5'h1F, 9'h055);
    rd(5'h0D, w(0, 0, 0, 0, 0, 0, 0, 9'h055), 1);
    $display("ext done");
  endtask
  // home agent bank, frozen clock enable, software write and clear, unmapped reads
  task automatic t_misc();
    ev(1, 1, 2'h2, MCELOG_KIND_OTHER, 5'h00, 5'h00, 0, 0, 9'h133);
    #1;
    chk("last", {59'h0, last}, {59'h0, MCELOG_HA_BANK_C1});
    rd(5'h08, w(0, 0, 0, 0, 0, 0, 0, 9'h133), 1);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    ev(0, 0, 2'h0, MCELOG_KIND_OTHER, 5'h00, 5'h00, 0, 0, 9'h0AA);
    clk_en <= 1'b1;
    #1;
    chk("last", {59'h0, last}, {59'h0, MCELOG_HA_BANK_C1});
    @(posedge ref_clk);
    sw <= '{1'b1, 1'b0, 5'h0C, 64'hFFFF_FFFF_FFFF_FFFF};
    @(posedge ref_clk);
    sw <= '0;
    rd(5'h0C, 64'hC0FF_FFFF_FFFF_FFFF, 1);
    @(posedge ref_clk);
    sw <= '{1'b0, 1'b1, 5'h0C, 64'h0};
    @(posedge ref_clk);
    sw <= '0;
    rd(5'h0C, 64'h0, 1);
    rd(5'h11, 64'h0, 0);
    rd(5'h06, 64'h0, 0);
    $display("misc done");
  endtask
  // verdict
  task automatic tally_and_finish();
    $display("checked %0d mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(5'h09, 64'h0, 1);
    t_wdb();
    t_ext();
    t_misc();
    tally_and_finish();
  end
endmodule
